// ===== design/pwm_pkg.sv
// constants and register map of the six-channel pulse-width generator core
// Overview of operation
// - six raw outputs derived from shared counter
// - output stage follows generator before pins
// - per-pin select bit picks pulse or GPIO
// - run bit 7 idles or starts counter
// - clear bit 4 zeroes counter, self-clears
// - period and duty are double buffered
// - load bit 6 transfers buffers at period end
// - load bit reads 1 until transfer done
// - flag bit 5 set by hardware, software clears
// - group bit 5 shares channel 0/1 duties
// - 3-bit divider prescales 1/1 to 1/128
// - source bit 6 picks sysclk or timer 1
// - period high byte 15:8, low 7:0
// - all channels share one 16-bit counter
// - compare counter against period and duty
// - group: ch2,4 use duty0; ch3,5 duty1
package pwm_pkg;
  localparam int          ADDR_W    = 10;
  localparam int          DATA_W    = 32;
  localparam int          NUM_CH    = 6;
  localparam int          CNT_W     = 16;
  localparam int          PRESC_W   = 7;
  localparam int          DIV_W     = 3;
  // register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_CLK_SRC  = 8'h8e;
  localparam logic [7:0]  IDX_PER_HI   = 8'hd1;
  localparam logic [7:0]  IDX_RUN_LOAD = 8'hd8;
  localparam logic [7:0]  IDX_PER_LO   = 8'hd9;
  localparam logic [7:0]  IDX_MODE_DIV = 8'hdf;
  localparam logic [7:0]  IDX_PIN_SEL  = 8'he4;
  localparam logic [7:0]  IDX_DUTY_LO [NUM_CH] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'he0, 8'he2};
  localparam logic [7:0]  IDX_DUTY_HI [NUM_CH] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'he1, 8'he3};
  // bit positions
  localparam int          RUN_BIT   = 7;
  localparam int          LOAD_BIT  = 6;
  localparam int          FLAG_BIT  = 5;
  localparam int          CLEAR_BIT = 4;
  localparam int          GROUP_BIT = 5;
  localparam int          CKS_BIT   = 6;
  localparam int          DIV_LSB   = 0;
  localparam logic [DIV_W-1:0] DIV_MAX = 3'h7;
  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
endpackage

// ===== design/pwm_counter_period_control.sv
// six-channel pulse-width generator core with Wishbone register slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pwm_counter_period_control (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [pwm_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [pwm_pkg::DATA_W-1:0]  wb_dat_i,
  output logic      [pwm_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        timer1_overflow,
  input  wire logic [pwm_pkg::NUM_CH-1:0]  gpio_out,
  output logic                             generator_out_0,
  output logic                             generator_out_1,
  output logic                             generator_out_2,
  output logic                             generator_out_3,
  output logic                             generator_out_4,
  output logic                             generator_out_5,
  output logic      [pwm_pkg::NUM_CH-1:0]  pin_out
);
  import pwm_pkg::*;

  logic                    ack_q;
  logic [DATA_W-1:0]       rdat_q;
  logic [DATA_W-1:0]       rdat_d;
  logic [7:0]              idx;
  logic [7:0]              wbyte;
  logic                    wr_en;
  logic                    load_set;
  logic                    clear_set;
  logic                    flag_wr0;
  logic                    run_q;
  logic                    load_q;
  logic                    flag_q;
  logic                    clear_q;
  logic                    cks_q;
  logic [7:0]              mode_div_q;
  logic [NUM_CH-1:0]       pin_sel_q;
  logic [7:0]              per_hi_q;
  logic [7:0]              per_lo_q;
  logic [CNT_W-1:0]        duty_buf_q [NUM_CH];
  logic [CNT_W-1:0]        period_act_q;
  logic [CNT_W-1:0]        duty_act_q [NUM_CH];
  logic [CNT_W-1:0]        duty_eff [NUM_CH];
  logic [CNT_W-1:0]        cnt_q;
  logic [PRESC_W-1:0]      presc_q;
  logic                    src_tick;
  logic                    tick;
  logic                    period_end;
  logic                    group_en;
  logic [DIV_W-1:0]        div_sel;
  logic [NUM_CH-1:0]       raw_q;

  // mask of prescaler bits that must all be set for one counter tick
  function automatic logic [PRESC_W-1:0] div_mask(input logic [DIV_W-1:0] d);
    div_mask = PRESC_W'({PRESC_W{1'b1}} >> (DIV_MAX - d));
  endfunction

  assign idx       = wb_adr_i[ADDR_W-1:2];
  assign wbyte     = wb_dat_i[7:0];
  // a write takes effect at the edge where ack is seen high
  assign wr_en     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign load_set  = wr_en & (idx == IDX_RUN_LOAD) & wbyte[LOAD_BIT];
  assign clear_set = wr_en & (idx == IDX_RUN_LOAD) & wbyte[CLEAR_BIT];
  assign flag_wr0  = wr_en & (idx == IDX_RUN_LOAD) & ~wbyte[FLAG_BIT];
  assign group_en  = mode_div_q[GROUP_BIT];
  assign div_sel   = mode_div_q[DIV_LSB +: DIV_W];
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q  <= wb_cyc_i & wb_stb_i & ~ack_q;
      rdat_q <= rdat_d;
    end
  end

  // unmapped indices read as zero and ignore writes
  always_comb begin
    rdat_d = '0;
    unique case (idx)
      IDX_CLK_SRC:  rdat_d[CKS_BIT] = cks_q;
      IDX_PER_HI:   rdat_d[7:0] = per_hi_q;
      IDX_PER_LO:   rdat_d[7:0] = per_lo_q;
      IDX_MODE_DIV: rdat_d[7:0] = mode_div_q;
      IDX_PIN_SEL:  rdat_d[NUM_CH-1:0] = pin_sel_q;
      IDX_RUN_LOAD: rdat_d[7:0] = {run_q, load_q, flag_q, clear_q, 4'h0};
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (idx == IDX_DUTY_LO[i]) begin
            rdat_d[7:0] = duty_buf_q[i][7:0];
          end
          if (idx == IDX_DUTY_HI[i]) begin
            rdat_d[7:0] = duty_buf_q[i][15:8];
          end
        end
      end
    endcase
  end

  // software-side buffers; the running compare never sees these directly
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      per_hi_q <= RST_BYTE;
      per_lo_q <= RST_BYTE;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_buf_q[i] <= RST_WORD;
      end
    end else if (wr_en) begin
      if (idx == IDX_PER_HI) begin
        per_hi_q <= wbyte;
      end
      if (idx == IDX_PER_LO) begin
        per_lo_q <= wbyte;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (idx == IDX_DUTY_LO[i]) begin
          duty_buf_q[i][7:0] <= wbyte;
        end
        if (idx == IDX_DUTY_HI[i]) begin
          duty_buf_q[i][15:8] <= wbyte;
        end
      end
    end
  end

  // plain control bits; run, clock source, mode/divider and pin select
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      run_q      <= 1'b0;
      cks_q      <= 1'b0;
      mode_div_q <= RST_BYTE;
      pin_sel_q  <= '0;
    end else if (wr_en) begin
      if (idx == IDX_RUN_LOAD) begin
        run_q <= wbyte[RUN_BIT];
      end
      if (idx == IDX_CLK_SRC) begin
        cks_q <= wbyte[CKS_BIT];
      end
      if (idx == IDX_MODE_DIV) begin
        mode_div_q <= wbyte;
      end
      if (idx == IDX_PIN_SEL) begin
        pin_sel_q <= wbyte[NUM_CH-1:0];
      end
    end
  end

  // self-clearing handshake bits and the sticky flag; a hardware set wins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      load_q  <= 1'b0;
      clear_q <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      if (load_set) begin
        load_q <= 1'b1;
      end else if (period_end) begin
        load_q <= 1'b0;
      end
      clear_q <= clear_set;
      if (period_end) begin
        flag_q <= 1'b1;
      end else if (flag_wr0) begin
        flag_q <= 1'b0;
      end
    end
  end

  // prescaler: timer 1 overflow is a same-clock pulse, so no synchroniser
  assign src_tick = cks_q ? timer1_overflow : 1'b1;
  assign tick     = run_q & src_tick & ((presc_q & div_mask(div_sel)) == div_mask(div_sel));

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      presc_q <= '0;
    end else if (clear_q || !run_q) begin
      presc_q <= '0;
    end else if (src_tick) begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // shared up counter; >= so a period shrunk below the count still wraps
  assign period_end = tick & ~clear_q & (cnt_q >= period_act_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= RST_WORD;
    end else if (clear_q) begin
      cnt_q <= RST_WORD;
    end else if (period_end) begin
      cnt_q <= RST_WORD;
    end else if (tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // active values change only at a period end with a load pending
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      period_act_q <= RST_WORD;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_act_q[i] <= RST_WORD;
      end
    end else if (load_q && period_end) begin
      period_act_q <= {per_hi_q, per_lo_q};
      for (int i = 0; i < NUM_CH; i++) begin
        duty_act_q[i] <= duty_buf_q[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      duty_eff[i] = (group_en && i >= 2) ? duty_act_q[i % 2] : duty_act_q[i];
    end
  end

  // raw generator outputs: high while the count is below the duty
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      raw_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        raw_q[i] <= run_q & (cnt_q < duty_eff[i]);
      end
    end
  end

  assign generator_out_0 = raw_q[0];
  assign generator_out_1 = raw_q[1];
  assign generator_out_2 = raw_q[2];
  assign generator_out_3 = raw_q[3];
  assign generator_out_4 = raw_q[4];
  assign generator_out_5 = raw_q[5];

  // output stage: dead-time, mask, brake and polarity live downstream,
  // here it only gates idle channels low and does the final pin select
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_out <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        pin_out[i] <= pin_sel_q[i] ? (raw_q[i] & run_q) : gpio_out[i];
      end
    end
  end

  // ---- assertions ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_load_due;
    load_q && period_end && !load_set;
  endsequence

  sequence s_load_done;
    !load_q && period_act_q == $past({per_hi_q, per_lo_q});
  endsequence

  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not given for exactly one cycle");

  a_load_transfer: assert property (s_load_due |=> s_load_done)
    else $error("load did not transfer period at period end");

  a_load_hold_bit: assert property (
    load_q && !period_end |=> load_q)
    else $error("load bit dropped before transfer");

  a_active_stable: assert property (
    !(load_q && period_end) |=> $stable(period_act_q) && $stable(duty_act_q[0]))
    else $error("active value changed without a load");

  a_clear_counter: assert property (
    clear_set |=> clear_q ##1 (cnt_q == RST_WORD && !clear_q))
    else $error("counter clear did not complete");

  a_idle_counter: assert property (
    !run_q && !clear_q |=> $stable(cnt_q) && raw_q == '0)
    else $error("counter moved or outputs high while idle");

  a_wrap_period: assert property (
    period_end |=> cnt_q == RST_WORD && flag_q)
    else $error("counter did not wrap or flag not set");

  a_flag_sticky: assert property (
    flag_q && !flag_wr0 |=> flag_q)
    else $error("flag cleared without software");

  a_group_share: assert property (
    group_en |-> duty_eff[4] == duty_act_q[0] && duty_eff[3] == duty_act_q[1])
    else $error("group mode duties not shared");

  a_half_rate: assert property (
    run_q && !cks_q && div_sel == 3'h1 && !clear_q && tick |=> !tick)
    else $error("divide by two ticked on consecutive cycles");

  a_pin_select: assert property (
    !pin_sel_q[0] |=> pin_out[0] == $past(gpio_out[0]))
    else $error("unselected pin not carrying gpio");

  a_raw_compare: assert property (
    run_q |=> generator_out_1 == ($past(cnt_q) < $past(duty_eff[1])))
    else $error("raw output does not follow the count compare");

  a_pulse_pin: assert property (
    pin_sel_q[1] |=> pin_out[1] == $past(generator_out_1 && run_q))
    else $error("selected pin not carrying the gated pulse");

  a_counter_step: assert property (
    tick && !period_end && !clear_q |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not advance by one on a tick");

  a_full_rate: assert property (
    run_q && !cks_q && div_sel == 3'h0 |-> tick)
    else $error("undivided system clock did not tick every cycle");

  a_timer_gate: assert property (
    cks_q && !timer1_overflow |-> !tick)
    else $error("counter ticked without a timer overflow");

  a_load_set_wins: assert property (
    load_set |=> load_q)
    else $error("load request not held pending");

  a_flag_clear: assert property (
    flag_wr0 && !period_end |=> !flag_q)
    else $error("software clear of the flag had no effect");

endmodule
`default_nettype wire

// ===== sim/pin_load.sv
// behavioural load on the pulse pins: counts the cycles each pin is driven high
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic       sys_clk,
  input  wire logic       clr,
  input  wire logic [5:0] pins,
  output int              hi_cnt [6]
);
  // a switch only sees a settled level once per clock, so sampling on the edge is enough
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 6; i++) begin
      hi_cnt[i] <= clr ? 0 : hi_cnt[i] + int'(pins[i]);
    end
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the pulse-width generator core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pwm_pkg::*;
  logic              sys_clk, rst_b, cyc, stb, we, t1, clr, tsrc;
  logic [ADDR_W-1:0] adr;
  logic [3:0]        sel;
  logic [DATA_W-1:0] dwr, drd;
  logic              ack;
  logic [5:0]        gpio, pins;
  wire  logic [5:0]  g;
  logic [7:0]        rd, psel, mdiv;
  int                hi_cnt [6];
  int                duty [6];
  int                exp_raw [6];
  int                exp_pin [6];
  int                fails, num_checks, per, mult, win;
  localparam logic [7:0] regs [6] = '{IDX_CLK_SRC, IDX_PER_HI, IDX_RUN_LOAD, IDX_PER_LO,
                                      IDX_MODE_DIV, 8'h00};

  pwm_counter_period_control pwm_counter_period_control_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
    .timer1_overflow(t1), .gpio_out(gpio), .generator_out_0(g[0]), .generator_out_1(g[1]),
    .generator_out_2(g[2]), .generator_out_3(g[3]), .generator_out_4(g[4]),
    .generator_out_5(g[5]), .pin_out(pins));
  pin_load pin_load_i (.sys_clk(sys_clk), .clr(clr), .pins(pins), .hi_cnt(hi_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // timer overflow toggles when selected, otherwise noise that must be ignored
  always @(posedge sys_clk) t1 <= tsrc ? ~t1 : 1'($urandom);

  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #250000;
    fails++;
    tally_and_finish();
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dwr <= {24'h000000, d};
    n = 0;
    // no answer time is assumed while waiting; only the watchdog ends a lost answer
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1);
    chk("ack wait edges", 32'h2, 32'(n));
    rd = drd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  function automatic int eff(int ch);
    int c;
    c = (mdiv[GROUP_BIT] && ch >= 2) ? ch % 2 : ch;
    return (duty[c] > per + 1) ? per + 1 : duty[c];
  endfunction
  task automatic expect_all(input logic running);
    for (int i = 0; i < 6; i++) begin
      exp_raw[i] = running ? win / (per + 1) * eff(i) : 0;
      exp_pin[i] = psel[i] ? exp_raw[i] : (gpio[i] ? win : 0);
    end
  endtask
  task automatic measure;
    int raw [6];
    raw = '{default: 0};
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (win) begin
      @(posedge sys_clk);
      for (int i = 0; i < 6; i++) raw[i] += int'(g[i]);
    end
    #1;
    for (int i = 0; i < 6; i++) begin
      chk("raw high cycles", exp_raw[i], raw[i]);
      chk("pin high cycles", exp_pin[i], hi_cnt[i]);
    end
  endtask

  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, clr, tsrc} = 5'h00;
    sel = 4'h1;
    adr = '0;
    dwr = '0;
    gpio = 6'h00;
    void'($urandom(32'h18e6994d));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      bus(0, regs[i], 8'h00);
      chk("reset value", 32'h0, {24'h0, rd});
    end
    bus(1, 8'h00, 8'hff);
    bus(1, IDX_CLK_SRC, 8'hff);
    bus(0, IDX_CLK_SRC, 8'h00);
    chk("source reg", 32'h40, {24'h0, rd});
    mdiv = 8'($urandom);
    bus(1, IDX_PER_HI, mdiv);
    bus(0, IDX_PER_HI, 8'h00);
    chk("period high", {24'h0, mdiv}, {24'h0, rd});
    bus(1, IDX_RUN_LOAD, 8'h10);
    for (int r = 0; r < 4; r++) begin
      per = $urandom_range(9, 2);
      for (int i = 0; i < 6; i++) begin
        duty[i] = (i == 0) ? $urandom_range(per, 1) : $urandom_range(per + 2, 0);
        bus(1, IDX_DUTY_LO[i], duty[i][7:0]);
        bus(1, IDX_DUTY_HI[i], 8'h00);
      end
      bus(1, IDX_PER_LO, per[7:0]);
      bus(1, IDX_PER_HI, 8'h00);
      // buffers written while running must not reach the comparators yet
      if (r > 0) measure();
      mdiv = {2'($urandom), r == 2, 2'($urandom), 3'(r)};
      tsrc = (r == 3);
      mult = (1 << r) * (tsrc ? 2 : 1);
      psel = 8'($urandom) & 8'h3f;
      bus(1, IDX_PIN_SEL, psel);
      gpio <= 6'($urandom);
      bus(1, IDX_MODE_DIV, mdiv);
      bus(1, IDX_CLK_SRC, {1'b0, tsrc, 6'h00});
      bus(1, IDX_RUN_LOAD, 8'hc0);
      for (int k = 0; k < 200; k++) begin
        bus(0, IDX_RUN_LOAD, 8'h00);
        if (rd[LOAD_BIT] === 1'b0) break;
      end
      chk("load pending", 32'h0, {31'h0, rd[LOAD_BIT]});
      win = 3 * (per + 1) * mult;
      expect_all(1'b1);
      repeat (win + 8) @(posedge sys_clk);
      measure();
    end
    bus(0, IDX_RUN_LOAD, 8'h00);
    chk("flag", 32'h1, {31'h0, rd[FLAG_BIT]});
    // stop first: a period end in the same cycle as the flag clear keeps the flag set
    bus(1, IDX_RUN_LOAD, 8'h00);
    bus(1, IDX_RUN_LOAD, 8'h00);
    bus(0, IDX_RUN_LOAD, 8'h00);
    chk("stopped control", 32'h0, {24'h0, rd});
    expect_all(1'b0);
    measure();
    // stopped counter sits mid-period; after clearing, the first high run is the full duty
    mdiv = 8'h00;
    tsrc = 1'b0;
    bus(1, IDX_MODE_DIV, mdiv);
    bus(1, IDX_CLK_SRC, 8'h00);
    bus(1, IDX_RUN_LOAD, 8'h10);
    bus(1, IDX_RUN_LOAD, 8'h80);
    for (int k = 0; k < 20 && g[0] !== 1'b1; k++) @(posedge sys_clk);
    win = 0;
    while (g[0] === 1'b1 && win < 20) begin
      win++;
      @(posedge sys_clk);
    end
    chk("first high run", duty[0], win);
    tally_and_finish();
  end
endmodule
`default_nettype wire
